// *** hdl/core_pkg.sv ***
// ****************************************************************
// Shared constants of the instruction timing and status core
// ****************************************************************
package core_pkg;
  // Widths
  localparam int PHASES = 4;                       // Phases per instruction cycle
  localparam int IW     = 14;                      // Instruction word width
  localparam int PCW    = 10;                      // Program counter width
  localparam int DW     = 8;                       // Data byte width
  localparam int DAW    = 8;                       // Data address: bank bit plus file
  localparam int FW     = 7;                       // File address within a bank
  localparam int FLW    = 3;                       // Arithmetic flag count
  localparam int WB_AW  = 4;                       // Register bus address width
  localparam int WB_DW  = 32;                      // Register bus data width

  // Status register bit positions
  localparam int ST_C   = 0;                       // Ripple out / borrow
  localparam int ST_DC  = 1;                       // Nibble carry / digit borrow
  localparam int ST_Z   = 2;                       // Result null
  localparam int ST_PD  = 3;                       // Sleep entered
  localparam int ST_TO  = 4;                       // Watchdog expiry
  localparam int ST_RP0 = 5;                       // Direct bank low
  localparam int ST_IRP = 7;                       // Indirect bank (top of bank field)

  // Reset values
  localparam logic [2:0]     BANK_RST   = 3'h0;   // Bank bits after reset
  localparam logic [2:0]     ARITH_RST  = 3'h0;   // Arithmetic flags after reset
  localparam logic [PCW-1:0] PC_RST     = 10'h000; // First fetch address
  localparam logic [IW-1:0]  NOP_WORD   = 14'h0000; // Empty instruction
  localparam logic           RUN_RST    = 1'b1;    // Core runs after reset
  localparam logic [PHASES-1:0] PH_RST  = 4'h1;    // Phase one first

  // Instruction fields
  localparam int OPC_HI = 13;                      // Opcode top bit
  localparam int OPC_LO = 10;                      // Opcode bottom bit
  localparam int BIT_HI = 9;                       // Bit select top
  localparam int BIT_LO = 7;                       // Bit select bottom
  localparam int DEST_B = 7;                       // Destination: 1 = file
  localparam int LIT_HI = 7;                       // Literal top bit
  localparam int NIB_HI = 4;                       // Nibble carry position

  // Opcodes
  localparam logic [3:0] OP_JUMP  = 4'h1;          // Load program counter
  localparam logic [3:0] OP_CLEAR_FILE_OP  = 4'h2;          // clear_file_op
  localparam logic [3:0] OP_BCF   = 4'h3;          // bit_clear_op
  localparam logic [3:0] OP_BSF   = 4'h4;          // bit_set_op
  localparam logic [3:0] OP_NIBBLE_SWAP_OP = 4'h5;          // nibble_swap_op
  localparam logic [3:0] OP_MOVE_W_TO_FILE_OP = 4'h6;          // move_w_to_file_op
  localparam logic [3:0] OP_ADDWF = 4'h7;          // Add working to file
  localparam logic [3:0] OP_SUBTRACT_REGISTER_OP = 4'h8;          // subtract_register_op
  localparam logic [3:0] OP_SUBTRACT_FROM_LITERAL_OP = 4'h9;          // subtract_from_literal_op
  localparam logic [3:0] OP_MOVLW = 4'hA;          // Literal to working
  localparam logic [3:0] OP_MOVF  = 4'hB;          // File move, tests null

  // Data memory map and flag masks
  localparam logic [FW-1:0]  STATUS_FILE = 7'h03;  // Status in every bank
  localparam logic [FLW-1:0] FLAG_NONE   = 3'h0;   // No flag touched
  localparam logic [FLW-1:0] FLAG_Z      = 3'h4;   // Null flag only
  localparam logic [FLW-1:0] FLAG_ALL    = 3'h7;   // All three flags

  // Register bus offsets
  localparam logic [WB_AW-1:0] ADR_CTRL = 4'h0;    // Run control
  localparam logic [WB_AW-1:0] ADR_PROG = 4'h4;    // Phase and program counter
  localparam logic [WB_AW-1:0] ADR_CORE = 4'h8;    // Latch, working, status
  localparam int CTRL_RUN = 0;                     // Run bit position
endpackage

// *** hdl/phase_gen.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Four-phase divider of the input clock
// ****************************************************************
module phase_gen (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // Control
  input  wire logic                        run_i,
  // One-hot phase
  output logic [core_pkg::PHASES-1:0]      phase_o
);
  import core_pkg::*;

  // Rotate one-hot phase, frozen while stopped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_o <= PH_RST;
    end else if (run_i) begin
      phase_o <= {phase_o[PHASES-2:0], phase_o[PHASES-1]};
    end
  end
endmodule // phase_gen

// *** hdl/status_reg.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Core status byte with protected bits
// ****************************************************************
module status_reg (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // Write-back from the pipeline
  input  wire logic                        commit_i,
  input  wire logic                        file_wr_i,
  input  wire logic [core_pkg::DW-1:0]     wdata_i,
  input  wire logic [core_pkg::FLW-1:0]    flag_mask_i,
  input  wire logic [core_pkg::FLW-1:0]    flags_i,
  // Reset-cause events
  input  wire logic                        wdog_expired_i,
  input  wire logic                        sleep_entered_i,
  input  wire logic                        wdog_cleared_i,
  // Status byte
  output logic [core_pkg::DW-1:0]          status_o
);
  import core_pkg::*;

  logic [2:0]     bank_q;                          // Bank select bits
  logic           to_q;                            // Watchdog expiry, low on expiry
  logic           pd_q;                            // Sleep entered, low in sleep
  logic [FLW-1:0] arith_q;                         // Null, nibble, ripple

  // One byte, like any file
  assign status_o = {bank_q, to_q, pd_q, arith_q};

  // Bank bits take plain file writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bank_q <= BANK_RST;
    end else if (commit_i && file_wr_i) begin
      bank_q <= wdata_i[ST_IRP:ST_RP0];
    end
  end

  // Arithmetic flags: flag logic beats the data write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arith_q <= ARITH_RST;
    end else if (commit_i) begin
      for (int i = 0; i < FLW; i++) begin
        if (flag_mask_i[i]) begin
          arith_q[i] <= flags_i[i];
        end else if (file_wr_i && flag_mask_i == FLAG_NONE) begin
          arith_q[i] <= wdata_i[i];
        end
      end
    end
  end

  // Reset-cause flags: only internal events move them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      to_q <= 1'b1;
      pd_q <= 1'b1;
    end else begin
      if (wdog_cleared_i) begin
        to_q <= 1'b1;
        pd_q <= 1'b1;
      end
      if (sleep_entered_i) begin
        to_q <= 1'b1;
        pd_q <= 1'b0;
      end
      if (wdog_expired_i) begin
        to_q <= 1'b0;
      end
    end
  end
endmodule // status_reg

// *** hdl/core_timing.sv ***
`timescale 1ns/1ps
// ****************************************************************
// What this block does
// - Clock divided into four repeating phases
// - Program counter advances once, at phase one
// - Next word latched at phase four
// - Fetch overlaps execute, one per cycle
// - Program counter changes take two cycles
// - Latch at phase one, execute phases two-four
// - Operand read phase two, result write four
// - Status byte: flags, reset causes, banks
// - Status accepted as any destination
// - Flag-setting ops: flag logic owns flags
// - Reset-cause flags ignore software writes
// - Clear on status: banks zero, null set
// - Subtract: ripple and nibble flags are inverted borrows (set on no borrow)
// - Bank bit plus 7-bit file address
// ****************************************************************
module core_timing (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // Wishbone slave
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [core_pkg::WB_AW-1:0]  wb_adr_i,
  input  wire logic [core_pkg::WB_DW-1:0]  wb_dat_i,
  input  wire logic [3:0]                  wb_sel_i,
  output logic [core_pkg::WB_DW-1:0]       wb_dat_o,
  output logic                             wb_ack_o,
  // Program memory
  output logic [core_pkg::PCW-1:0]         pmem_addr_o,
  input  wire logic [core_pkg::IW-1:0]     pmem_data_i,
  // Data memory
  output logic [core_pkg::DAW-1:0]         dmem_addr_o,
  output logic                             dmem_rd_o,
  input  wire logic [core_pkg::DW-1:0]     dmem_rdata_i,
  output logic                             dmem_wr_o,
  output logic [core_pkg::DW-1:0]          dmem_wdata_o,
  // Reset-cause events
  input  wire logic                        wdog_expired_i,
  input  wire logic                        sleep_entered_i,
  input  wire logic                        wdog_cleared_i,
  // Core view
  output logic [core_pkg::PHASES-1:0]      phase_o,
  output logic [core_pkg::DW-1:0]          status_o
);
  import core_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic           run_q;                           // Phases advance when set
  logic [PCW-1:0] pc_q;                            // program_counter
  logic [IW-1:0]  prefetch_q;                      // Word fetched ahead
  logic [IW-1:0]  ir_q;                            // instruction_latch
  logic [IW-1:0]  ir_d;                            // Word entering the latch
  logic           flush_q;                         // Drop the prefetched word
  logic [DW-1:0]  w_q;                             // Working register
  logic [DW-1:0]  res_q;                           // Result held for phase four
  logic [FLW-1:0] flags_q;                         // Flags held for phase four
  logic [FLW-1:0] fmask_q;                         // Flags touched by the op
  logic           ph1;                             // Active in phase one
  logic           ph2;                             // Active in phase two
  logic           ph3;                             // Active in phase three
  logic           ph4;                             // Active in phase four
  logic           bus_req;                         // New bus request
  // Decode of the executing word
  logic [3:0]     opc;                             // Opcode
  logic [FW-1:0]  file;                            // File address
  logic [DW-1:0]  lit;                             // Literal
  logic           is_status;                       // File is the status byte
  logic           to_file;                         // Result goes to a file
  logic           to_w;                            // Result goes to working
  // Arithmetic
  logic [DW-1:0]  src;                             // Source operand
  logic [DW-1:0]  bitmask;                         // Bit op mask
  logic           sub;                             // Subtract form
  logic [DW-1:0]  add_a;                           // Adder first input
  logic [DW-1:0]  add_b;                           // Adder second input
  logic [DW:0]    sum9;                            // Byte sum with ripple out
  logic [NIB_HI:0] nib5;                           // Nibble sum with carry
  logic [DW-1:0]  res;                             // Result
  logic [FLW-1:0] fl;                              // New flag values
  logic [FLW-1:0] fmask;                           // Flags this op updates

  // File operand check for any word
  function automatic logic file_op(input logic [3:0] op);
    file_op = (op == OP_CLEAR_FILE_OP) || (op == OP_BCF) || (op == OP_BSF) ||
              (op == OP_NIBBLE_SWAP_OP) || (op == OP_MOVE_W_TO_FILE_OP) || (op == OP_ADDWF) ||
              (op == OP_SUBTRACT_REGISTER_OP) || (op == OP_MOVF);
  endfunction

  // ****************************************************************
  // Phase generation
  // ****************************************************************
  phase_gen u_phase (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (run_q),
    .phase_o (phase_o)
  );

  // Phase enables, held off while stopped
  assign ph1 = run_q && phase_o[0];
  assign ph2 = run_q && phase_o[1];
  assign ph3 = run_q && phase_o[2];
  assign ph4 = run_q && phase_o[3];

  // ****************************************************************
  // Fetch stage
  // ****************************************************************
  // Word handed to execute, empty after a jump
  assign ir_d = flush_q ? NOP_WORD : prefetch_q;

  // Program counter and fetch address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_q        <= PC_RST;
      pmem_addr_o <= PC_RST;
    end else if (ph1) begin
      pmem_addr_o <= pc_q;
      pc_q        <= pc_q + 1'b1;
    end else if (ph4 && opc == OP_JUMP) begin
      pc_q        <= ir_q[BIT_HI:0];
    end
  end

  // Prefetch capture and flush marker
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prefetch_q <= NOP_WORD;
      flush_q    <= 1'b0;
    end else if (ph4) begin
      prefetch_q <= pmem_data_i;
      flush_q    <= (opc == OP_JUMP);
    end else if (ph1) begin
      flush_q    <= 1'b0;
    end
  end

  // Instruction latch loads as the new cycle starts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ir_q <= NOP_WORD;
    end else if (ph1) begin
      ir_q <= ir_d;
    end
  end

  // ****************************************************************
  // Decode
  // ****************************************************************
  assign opc       = ir_q[OPC_HI:OPC_LO];
  assign file      = ir_q[FW-1:0];
  assign lit       = ir_q[LIT_HI:0];
  assign is_status = file_op(opc) && (file == STATUS_FILE);
  assign bitmask   = 8'h01 << ir_q[BIT_HI:BIT_LO];

  // Destination select
  always_comb begin
    to_file = 1'b0;
    to_w    = 1'b0;
    case (opc)
      OP_CLEAR_FILE_OP, OP_BCF, OP_BSF, OP_MOVE_W_TO_FILE_OP: begin
        to_file = 1'b1;
      end
      OP_NIBBLE_SWAP_OP, OP_ADDWF, OP_SUBTRACT_REGISTER_OP, OP_MOVF: begin
        to_file = ir_q[DEST_B];
        to_w    = !ir_q[DEST_B];
      end
      OP_SUBTRACT_FROM_LITERAL_OP, OP_MOVLW: begin
        to_w    = 1'b1;
      end
      default: begin
        to_file = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // Arithmetic, valid in phase three
  // ****************************************************************
  // Status byte read internally, never from memory
  assign src   = is_status ? status_o : dmem_rdata_i;
  assign sub   = (opc == OP_SUBTRACT_REGISTER_OP) || (opc == OP_SUBTRACT_FROM_LITERAL_OP);
  assign add_a = (opc == OP_SUBTRACT_FROM_LITERAL_OP) ? lit : src;
  // Subtract adds the two's complement of working
  assign add_b = sub ? ~w_q : w_q;
  assign sum9  = {1'b0, add_a} + {1'b0, add_b} + {8'h00, sub};
  assign nib5  = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, sub};

  // Result and flag selection
  always_comb begin
    res   = src;
    fmask = FLAG_NONE;
    case (opc)
      OP_CLEAR_FILE_OP: begin
        res   = 8'h00;
        fmask = FLAG_Z;
      end
      OP_BCF: begin
        res   = src & ~bitmask;
      end
      OP_BSF: begin
        res   = src | bitmask;
      end
      OP_NIBBLE_SWAP_OP: begin
        res   = {src[3:0], src[7:4]};
      end
      OP_MOVE_W_TO_FILE_OP: begin
        res   = w_q;
      end
      OP_MOVLW: begin
        res   = lit;
      end
      OP_MOVF: begin
        fmask = FLAG_Z;
      end
      OP_ADDWF, OP_SUBTRACT_REGISTER_OP, OP_SUBTRACT_FROM_LITERAL_OP: begin
        res   = sum9[DW-1:0];
        fmask = FLAG_ALL;
      end
      default: begin
        res   = src;
      end
    endcase
  end

  // Ripple and nibble carry read as no-borrow in subtraction
  always_comb begin
    fl       = FLAG_NONE;
    fl[ST_Z] = (res == 8'h00);
    fl[ST_DC] = nib5[NIB_HI];
    fl[ST_C] = sum9[DW];
  end

  // ****************************************************************
  // Data memory strobes
  // ****************************************************************
  // Operand read: address set in phase one, strobe high in phase two
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dmem_addr_o <= 8'h00;
      dmem_rd_o   <= 1'b0;
    end else if (ph1) begin
      dmem_addr_o <= {status_o[ST_RP0], ir_d[FW-1:0]};
      dmem_rd_o   <= file_op(ir_d[OPC_HI:OPC_LO]) &&
                     (ir_d[FW-1:0] != STATUS_FILE);
    end else if (ph2) begin
      dmem_rd_o   <= 1'b0;
    end
  end

  // Destination write: strobe high in phase four
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dmem_wr_o    <= 1'b0;
      dmem_wdata_o <= 8'h00;
    end else if (ph3) begin
      dmem_wr_o    <= to_file && !is_status;
      dmem_wdata_o <= res;
    end else if (ph4) begin
      dmem_wr_o    <= 1'b0;
    end
  end

  // Result and flags held for write-back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_q   <= 8'h00;
      flags_q <= FLAG_NONE;
      fmask_q <= FLAG_NONE;
    end else if (ph3) begin
      res_q   <= res;
      flags_q <= fl;
      fmask_q <= fmask;
    end
  end

  // Working register write-back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      w_q <= 8'h00;
    end else if (ph4 && to_w) begin
      w_q <= res_q;
    end
  end

  // ****************************************************************
  // Status register
  // ****************************************************************
  status_reg u_status (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .commit_i        (ph4),
    .file_wr_i       (to_file && is_status),
    .wdata_i         (res_q),
    .flag_mask_i     (fmask_q),
    .flags_i         (flags_q),
    .wdog_expired_i  (wdog_expired_i),
    .sleep_entered_i (sleep_entered_i),
    .wdog_cleared_i  (wdog_cleared_i),
    .status_o        (status_o)
  );

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Acknowledge one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Read data, zero for unmapped offsets
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (bus_req) begin
      case (wb_adr_i)
        ADR_CTRL: wb_dat_o <= {31'h00000000, run_q};
        ADR_PROG: wb_dat_o <= {18'h00000, phase_o, pc_q};
        ADR_CORE: wb_dat_o <= {2'h0, ir_q, w_q, status_o};
        default:  wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // Run control, written on the acknowledge edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_q <= RUN_RST;
    end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
                 wb_sel_i[0] && wb_adr_i == ADR_CTRL) begin
      run_q <= wb_dat_i[CTRL_RUN];
    end
  end
endmodule // core_timing

// *** sim/core_timing_properties.sv ***
`timescale 1ns/1ps
module core_timing_chk (
  input wire logic       clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o,
  input wire logic       dmem_rd_o, dmem_wr_o,
  input wire logic       wdog_expired_i, sleep_entered_i, wdog_cleared_i,
  input wire logic [9:0] pmem_addr_o,
  input wire logic [7:0] dmem_addr_o, status_o,
  input wire logic [3:0] phase_o
);
  logic [3:0] ph_q; // Phase one cycle back
  logic [1:0] ev_q; // Recent cause events
  // Helper history
  always_ff @(posedge clk_i) begin
    ph_q <= phase_o;
    ev_q <= {ev_q[0], wdog_expired_i | sleep_entered_i | wdog_cleared_i};
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_hot; $onehot(phase_o); endproperty
  a_hot: assert property (p_hot) else $error("phase not one-hot");
  property p_seq; phase_o != ph_q |-> phase_o == {ph_q[2:0], ph_q[3]}; endproperty
  a_seq: assert property (p_seq) else $error("phase order");
  property p_pc; $changed(pmem_addr_o) |-> phase_o == 4'h2; endproperty
  a_pc: assert property (p_pc) else $error("fetch moved off phase one");
  property p_hold; $changed(pmem_addr_o) |=> $stable(pmem_addr_o) [*3]; endproperty
  a_hold: assert property (p_hold) else $error("fetch faster than a cycle");
  property p_rd; dmem_rd_o |-> phase_o == 4'h2 && dmem_addr_o[7] == status_o[5]; endproperty
  a_rd: assert property (p_rd) else $error("operand read misplaced");
  property p_wr; dmem_wr_o |-> phase_o == 4'h8 ##1 !dmem_wr_o; endproperty
  a_wr: assert property (p_wr) else $error("result write misplaced");
  property p_fl; $changed({status_o[7:5], status_o[2:0]}) |-> phase_o == 4'h1; endproperty
  a_fl: assert property (p_fl) else $error("status moved off phase four");
  property p_cause; $changed(status_o[4:3]) |-> ev_q != 2'h0; endproperty
  a_cause: assert property (p_cause) else $error("cause flags moved alone");
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus answer late or long");
  c_wr: cover property (dmem_wr_o);
  c_cause: cover property ($changed(status_o[4:3]));
  c_ack: cover property (wb_ack_o);
endmodule // core_timing_chk
bind core_timing core_timing_chk i_chk (.*);

// *** sim/mem_model.sv ***
`timescale 1ns/1ps
module mem_model (
  input  wire logic        clk_i,
  input  wire logic [9:0]  pmem_addr_i,
  output logic      [13:0] pmem_data_o,
  input  wire logic [7:0]  dmem_addr_i, dmem_wdata_i,
  input  wire logic        dmem_rd_i, dmem_wr_i,
  output logic      [7:0]  dmem_rdata_o
);
  logic [13:0] prog [0:1023]; // Program words, loaded by the bench
  logic [7:0]  ram [0:255];   // Data bytes
  // Registered reads; idle read data toggles
  always_ff @(posedge clk_i) begin
    pmem_data_o <= prog[pmem_addr_i];
    if (dmem_wr_i) ram[dmem_addr_i] <= dmem_wdata_i;
    dmem_rdata_o <= dmem_rd_i ? ram[dmem_addr_i] : ~dmem_rdata_o;
  end
endmodule // mem_model

// *** sim/core_timing_bench.sv ***
`timescale 1ns/1ps
module core_timing_bench;
  import core_pkg::*;
  logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic        wdog_expired_i = 0, sleep_entered_i = 0, wdog_cleared_i = 0;
  logic        dmem_rd_o, dmem_wr_o;
  logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hF, phase_o, p;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [9:0]  pmem_addr_o, pa_q;
  logic [13:0] pmem_data_i;
  logic [7:0]  dmem_addr_o, dmem_rdata_i, dmem_wdata_o, status_o;
  int          err_total = 0, n_checks = 0, w, st, r, t, f;
  int          exp_st [int]; // Status due when a fetch address shows
  int          exp_wr [$];   // Due data writes {addr, data}
  always #2 clk_i = ~clk_i;
  core_timing i_dut (.*);
  mem_model i_mem (.clk_i, .pmem_addr_i(pmem_addr_o), .pmem_data_o(pmem_data_i),
    .dmem_addr_i(dmem_addr_o), .dmem_wdata_i(dmem_wdata_o), .dmem_rd_i(dmem_rd_o),
    .dmem_wr_i(dmem_wr_o), .dmem_rdata_o(dmem_rdata_i));
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic stop_test();
    if (err_total == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wb(logic we, logic [3:0] a, logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    if (t >= 50) chk("bus answer", 1, 0);
  endtask
  // Write and status monitor
  always @(posedge clk_i) if (!rst_i) begin
    if (dmem_wr_o === 1'b1) chk("data write", exp_wr.size() ? exp_wr.pop_front() : -1, {dmem_addr_o, dmem_wdata_o});
    if (pmem_addr_o !== pa_q && exp_st.exists(pmem_addr_o)) chk("status", exp_st[pmem_addr_o], status_o);
    // Loop-address expectation follows the reset-cause events, expiry last
    if (wdog_cleared_i) exp_st[15] = exp_st[15] | 'h18;
    if (sleep_entered_i) exp_st[15] = (exp_st[15] & 'hF7) | 'h10;
    if (wdog_expired_i) exp_st[15] = exp_st[15] & 'hEF;
    pa_q = pmem_addr_o;
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    stop_test();
  end
  initial begin
    void'($urandom(1647));
    w = $urandom & 'h27;
    i_mem.prog[0] = {OP_MOVLW, 2'h0, w[7:0]};
    i_mem.prog[1] = {OP_MOVE_W_TO_FILE_OP, 3'h1, STATUS_FILE};
    i_mem.prog[2] = {OP_CLEAR_FILE_OP, 3'h1, STATUS_FILE};
    i_mem.prog[3] = {OP_JUMP, 10'h006};
    i_mem.prog[4] = {OP_MOVE_W_TO_FILE_OP, 3'h1, STATUS_FILE};
    i_mem.prog[6] = {OP_MOVLW, 2'h0, 8'h01};
    i_mem.prog[7] = {OP_SUBTRACT_FROM_LITERAL_OP, 2'h0, 8'h10};
    i_mem.prog[8] = {OP_MOVE_W_TO_FILE_OP, 3'h1, 7'h20};
    i_mem.prog[9] = {OP_MOVF, 3'h0, 7'h20};
    i_mem.prog[10] = {OP_BSF, 3'h7, 7'h20};
    i_mem.prog[11] = {OP_SUBTRACT_REGISTER_OP, 3'h0, 7'h20};
    i_mem.prog[12] = {OP_ADDWF, 3'h1, 7'h20};
    i_mem.prog[13] = {OP_BCF, 3'h0, STATUS_FILE};
    i_mem.prog[14] = {OP_MOVE_W_TO_FILE_OP, 3'h1, 7'h21};
    i_mem.prog[15] = {OP_JUMP, 10'h00F};
    st = 'h18;
    exp_st[2] = st;
    st = (st & 'h18) | w;
    exp_st[3] = st;
    st = (st & 'h1B) | 'h04;
    exp_st[4] = st;
    exp_st[5] = -1;
    exp_st[6] = st;
    exp_st[7] = st;
    exp_st[8] = st;
    r = 'h10 - 'h01;
    st = (st & 'hF8) | 4 * (r == 0) | 2 * ('h0 >= 'h1) | ('h10 >= 'h01);
    exp_st[9] = st;
    exp_st[10] = st;
    exp_wr.push_back('h2000 | r);
    f = r | 'h80; // Bit set on the file
    exp_wr.push_back('h2000 | f);
    exp_st[11] = st;
    exp_st[12] = st;
    st = (st & 'hF8) | 4 * (f == r) | 2 * (f % 16 >= r % 16) | (f >= r);
    exp_st[13] = st;
    r = f - r;
    st = (st & 'hF8) | 4 * ((f + r) % 256 == 0) | 2 * (f % 16 + r % 16 > 15) | (f + r > 255);
    exp_st[14] = st;
    f = (f + r) % 256;
    exp_wr.push_back('h2000 | f);
    st = st & 'hFE;
    exp_st[15] = st;
    exp_wr.push_back('h2100 | r);
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    t = 0;
    while (pmem_addr_o !== 10'h00F && t < 200) begin
      @(posedge clk_i);
      t++;
    end
    repeat (8) @(posedge clk_i);
    chk("writes done", 0, exp_wr.size());
    wb(0, ADR_CORE, 0);
    chk("core", (r << 8) | st, {16'h0, rd[15:0]});
    chk("latch", 1, rd[29:16] == {OP_JUMP, 10'h00F} || rd[29:16] == NOP_WORD);
    wb(0, ADR_CTRL, 0);
    chk("ctrl", 1, rd);
    wb(1, ADR_PROG, '1);
    wb(0, ADR_PROG, 0);
    chk("prog", 1, $onehot(rd[13:10]) && rd[9:0] >= 15 && rd[9:0] <= 17);
    wb(0, 4'hC, 0);
    chk("unmapped", 0, rd);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i);
      {wdog_expired_i, sleep_entered_i, wdog_cleared_i} <= 3'h4 >> i;
      @(posedge clk_i);
      {wdog_expired_i, sleep_entered_i, wdog_cleared_i} <= 3'h0;
      repeat (3) @(posedge clk_i);
      st = i == 0 ? st & 'hEF : i == 1 ? (st & 'hF7) | 'h10 : st | 'h18;
      chk("cause flags", st, status_o);
    end
    wb(1, ADR_CTRL, 0);
    @(posedge clk_i);
    p = phase_o;
    repeat (6) @(posedge clk_i);
    chk("frozen phase", p, phase_o);
    wb(1, ADR_CTRL, 1);
    repeat (8) @(posedge clk_i);
    stop_test();
  end
endmodule // core_timing_bench
